//--- hw/cts_defines.vh
/*
 Register offsets, field positions, reset values and counts for the
 capacitive touch acquisition block. Assumes inclusion by bare name.
*/
`ifndef CTS_DEFINES_VH
`define CTS_DEFINES_VH
`define CTS_OFF_CTRL 8'h00
`define CTS_OFF_CNT 8'h04
`define CTS_OFF_TIMING 8'h08
`define CTS_OFF_IDLE 8'h0c
`define CTS_OFF_LEVEL 8'h10
`define CTS_OFF_RAW 8'h14
`define CTS_OFF_LIMIT 8'h18
`define CTS_OFF_IER 8'h20
`define CTS_OFF_IDR 8'h24
`define CTS_OFF_IMR 8'h28
`define CTS_OFF_ISR 8'h2c
`define CTS_OFF_SCR 8'h30
`define CTS_OFF_PIN 8'h34
`define CTS_OFF_DMA 8'h38
`define CTS_CR_EN 0
`define CTS_CR_RUN 1
`define CTS_CR_BASELINE_LOAD_BIT 2
`define CTS_CR_PAIRED_PIN_FLAG 3
`define CTS_CR_INTRES 4
`define CTS_CR_CKSEL 5
`define CTS_CR_TRANSFER_MODE_BIT 6
`define CTS_CR_ESAMPLES 7
`define CTS_CTRL_RST 8'h00
`define CTS_ISR_SAMPLE 0
`define CTS_ISR_TOUCH_ENTER_FLAG 1
`define CTS_ISR_TOUCH_EXIT_FLAG 2
`define CTS_CHARGE_CYC 8'h04
`define CTS_NPINS 16
`define CTS_DMA_WORDS 3'h5
`endif

//--- hw/cts_touch_unit.v
/*
 Touch sensor unit: register file, charge/discharge sequencer, filter
 (median3, baseline tracker, smoothing) and touch detection.
 Assumes sense pins are synchronous to i_sys_clk and the measurement clock
 is presented as a one-cycle enable pulse from the clock source.
*/
`include "cts_defines.vh"
module cts_touch_unit (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_acq_tick,
  input wire i_acq_clk_ok,
  input wire i_event_trig,
  input wire [15:0] i_sense_in,
  output wire [15:0] o_sense_out,
  output wire [15:0] o_sense_oe_n,
  output wire o_bleed_pin,
  output wire o_rc_osc_req,
  output wire o_clk_req,
  output wire o_irq,
  output wire o_dma_rx_req,
  output wire o_dma_tx_req
);
  localparam ST_IDLE = 5'h01;
  localparam ST_CHARGE = 5'h02;
  localparam ST_DISCH = 5'h04;
  localparam ST_FILT = 5'h08;
  localparam ST_DMA = 5'h10;
  reg [7:0] ctrl_ff;
  reg [15:0] top_ff;
  reg [3:0] rep_ff;
  reg [11:0] baseline_smoothing_coeff_ff;
  reg [11:0] output_smoothing_coeff_ff;
  reg [3:0] pin_ff;
  reg [19:0] limit_ff;
  reg [2:0] imr_ff;
  reg [2:0] isr_ff;
  reg [19:0] idle_ff;
  reg [19:0] level_ff;
  reg [19:0] raw0_ff;
  reg [19:0] raw1_ff;
  reg [19:0] raw2_ff;
  reg touch_ff;
  reg [4:0] st_ff;
  reg [17:0] cnt_ff;
  reg [3:0] rpt_ff;
  reg [19:0] meas_ff;
  reg [19:0] acc_ff;
  reg phase_ff;
  reg go_ff;
  reg [31:0] dma_words_ff [0:4];
  reg [2:0] dma_idx_ff;
  reg dma_dir_ff;
  reg [2:0] nxt_isr;
  function [19:0] med3;
    input [19:0] a;
    input [19:0] b;
    input [19:0] c;
    reg signed [19:0] sa;
    reg signed [19:0] sb;
    reg signed [19:0] sc;
    begin
      sa = a;
      sb = b;
      sc = c;
      if ((sa >= sb && sa <= sc) || (sa <= sb && sa >= sc))
        med3 = a;
      else if ((sb >= sa && sb <= sc) || (sb <= sa && sb >= sc))
        med3 = b;
      else
        med3 = c;
    end
  endfunction
  // Product of signed 20-bit value and unsigned 12-bit fraction
  function [19:0] fmul;
    input [19:0] v;
    input [11:0] k;
    reg signed [32:0] p;
    begin
      p = $signed(v) * $signed({1'b0, k});
      fmul = p[31:12];
    end
  endfunction
  // One-hot mask for a sense pin index
  function [15:0] pin_bit;
    input [3:0] idx;
    begin
      pin_bit = 16'h0001 << idx;
    end
  endfunction
  // Last tick of a charge or discharge window
  function win_done;
    input [17:0] cnt;
    input [17:0] win;
    begin
      win_done = (cnt >= win - 18'h00001);
    end
  endfunction
  wire en_w = ctrl_ff[`CTS_CR_EN];
  wire run_w = ctrl_ff[`CTS_CR_RUN];
  wire paired_pin_flag_w = ctrl_ff[`CTS_CR_PAIRED_PIN_FLAG];
  wire transfer_mode_bit_w = ctrl_ff[`CTS_CR_TRANSFER_MODE_BIT];
  wire cfg_wr = i_wr & en_w;
  wire [3:0] pin_b = pin_ff + 4'h1;
  // Each window is top ticks; paired mode runs two phases, so the sample period doubles there
  wire [17:0] win_w = {2'b00, top_ff};
  wire sensed = paired_pin_flag_w ? (i_sense_in[pin_ff] | i_sense_in[pin_b]) : i_sense_in[pin_ff];
  wire [19:0] raw_n = acc_ff - idle_ff;
  wire [19:0] med_w = med3(raw2_ff, raw1_ff, raw_n);
  wire [19:0] half_lim = {1'b0, limit_ff[19:1]};
  wire dma_acc = (i_wr | i_rd) & (i_addr == `CTS_OFF_DMA) & transfer_mode_bit_w;
  // Charge phase drives sensor pins; tristate style, low enable drives
  wire drv = (st_ff == ST_CHARGE);
  wire [15:0] sel_a = pin_bit(pin_ff);
  wire [15:0] sel_b = paired_pin_flag_w ? pin_bit(pin_b) : 16'h0000;
  assign o_sense_out = phase_ff ? sel_a : (sel_a | sel_b);
  // Paired mode alternates polarity to pick up the mutual term
  assign o_sense_oe_n = drv ? ~(sel_a | sel_b) : 16'hffff;
  assign o_bleed_pin = (st_ff == ST_DISCH) & ~paired_pin_flag_w & ~ctrl_ff[`CTS_CR_INTRES];
  assign o_rc_osc_req = run_w & ~ctrl_ff[`CTS_CR_CKSEL] & (st_ff != ST_IDLE);
  assign o_clk_req = (run_w & (st_ff != ST_IDLE)) | i_event_trig;
  assign o_irq = |(isr_ff & imr_ff);
  assign o_dma_rx_req = (st_ff == ST_DMA) & ~dma_dir_ff;
  assign o_dma_tx_req = (st_ff == ST_DMA) & dma_dir_ff;
  always @*
  begin
    nxt_isr = isr_ff;
    if (i_wr && i_addr == `CTS_OFF_SCR)
      nxt_isr = isr_ff & ~i_wdata[2:0];
    // Set wins over a same-cycle clear; no overrun tracking
    if (st_ff == ST_FILT)
    begin
      nxt_isr[`CTS_ISR_SAMPLE] = 1'b1;
      if (!touch_ff && $signed(level_ff) > $signed(limit_ff))
        nxt_isr[`CTS_ISR_TOUCH_ENTER_FLAG] = 1'b1;
      if (touch_ff && $signed(level_ff) < $signed(half_lim))
        nxt_isr[`CTS_ISR_TOUCH_EXIT_FLAG] = 1'b1;
    end
  end
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ctrl_ff <= `CTS_CTRL_RST;
      top_ff <= 16'h0000;
      rep_ff <= 4'h0;
      baseline_smoothing_coeff_ff <= 12'h000;
      output_smoothing_coeff_ff <= 12'h000;
      pin_ff <= 4'h0;
      limit_ff <= 20'h00000;
      imr_ff <= 3'h0;
      isr_ff <= 3'h0;
      idle_ff <= 20'h00000;
      level_ff <= 20'h00000;
      raw0_ff <= 20'h00000;
      raw1_ff <= 20'h00000;
      raw2_ff <= 20'h00000;
      touch_ff <= 1'b0;
      st_ff <= ST_IDLE;
      cnt_ff <= 18'h00000;
      rpt_ff <= 4'h0;
      meas_ff <= 20'h00000;
      acc_ff <= 20'h00000;
      phase_ff <= 1'b0;
      go_ff <= 1'b0;
      dma_idx_ff <= 3'h0;
      dma_dir_ff <= 1'b0;
    end
    else
    begin
      isr_ff <= nxt_isr;
      if (cfg_wr)
      begin
        case (i_addr)
          `CTS_OFF_CTRL: ctrl_ff <= i_wdata[7:0];
          `CTS_OFF_CNT:
          begin
            top_ff <= i_wdata[15:0];
            rep_ff <= i_wdata[19:16];
          end
          `CTS_OFF_TIMING:
          begin
            baseline_smoothing_coeff_ff <= i_wdata[11:0];
            output_smoothing_coeff_ff <= i_wdata[27:16];
          end
          `CTS_OFF_IDLE: idle_ff <= i_wdata[19:0];
          `CTS_OFF_LEVEL: level_ff <= i_wdata[19:0];
          `CTS_OFF_LIMIT: limit_ff <= i_wdata[19:0];
          `CTS_OFF_IER: imr_ff <= imr_ff | i_wdata[2:0];
          `CTS_OFF_IDR: imr_ff <= imr_ff & ~i_wdata[2:0];
          `CTS_OFF_PIN: pin_ff <= i_wdata[3:0];
          default: ;
        endcase
      end
      else if (i_wr && i_addr == `CTS_OFF_CTRL)
        ctrl_ff[`CTS_CR_EN] <= i_wdata[`CTS_CR_EN];
      // DMA register accesses rotate state words as handshakes
      if (dma_acc && st_ff == ST_DMA)
      begin
        if (!dma_dir_ff && i_wr)
          dma_words_ff[dma_idx_ff] <= i_wdata;
        if (dma_idx_ff == `CTS_DMA_WORDS - 3'h1)
        begin
          dma_idx_ff <= 3'h0;
          dma_dir_ff <= ~dma_dir_ff;
          if (!dma_dir_ff)
          begin
            limit_ff <= dma_words_ff[0][19:0];
            idle_ff <= dma_words_ff[1][19:0];
            level_ff <= dma_words_ff[2][19:0];
            st_ff <= ST_CHARGE;
          end
          else
            st_ff <= ST_DMA;
        end
        else
          dma_idx_ff <= dma_idx_ff + 3'h1;
      end
      else if (!run_w || !i_acq_clk_ok)
      begin
        // Lost clock or stop leaves the partial measurement unused
        st_ff <= ST_IDLE;
        go_ff <= 1'b0;
      end
      else
      begin
        // Keeps converting with no debug-halt input
        case (st_ff)
          ST_IDLE:
          begin
            if (i_event_trig || !go_ff)
            begin
              go_ff <= 1'b1;
              st_ff <= transfer_mode_bit_w ? ST_DMA : ST_CHARGE;
              rpt_ff <= 4'h0;
              acc_ff <= 20'h00000;
              phase_ff <= 1'b0;
              cnt_ff <= 18'h00000;
            end
          end
          ST_CHARGE:
          begin
            if (i_acq_tick)
            begin
              cnt_ff <= cnt_ff + 18'h00001;
              if (win_done(cnt_ff, win_w))
              begin
                st_ff <= ST_DISCH;
                cnt_ff <= 18'h00000;
                meas_ff <= 20'h00000;
              end
            end
          end
          ST_DISCH:
          begin
            if (i_acq_tick)
            begin
              cnt_ff <= cnt_ff + 18'h00001;
              if (sensed)
                meas_ff <= meas_ff + 20'h00001;
              if (win_done(cnt_ff, win_w))
              begin
                cnt_ff <= 18'h00000;
                if (paired_pin_flag_w && !phase_ff)
                begin
                  phase_ff <= 1'b1;
                  st_ff <= ST_CHARGE;
                end
                else
                begin
                  phase_ff <= 1'b0;
                  acc_ff <= acc_ff + meas_ff;
                  rpt_ff <= rpt_ff + 4'h1;
                  // Repeat count plus one passes summed
                  st_ff <= (rpt_ff == rep_ff) ? ST_FILT : ST_CHARGE;
                end
              end
            end
          end
          ST_FILT:
          begin
            raw2_ff <= raw1_ff;
            raw1_ff <= raw_n;
            raw0_ff <= acc_ff;
            if (ctrl_ff[`CTS_CR_BASELINE_LOAD_BIT])
            begin
              idle_ff <= acc_ff;
              ctrl_ff[`CTS_CR_BASELINE_LOAD_BIT] <= 1'b0;
            end
            else
              idle_ff <= idle_ff + fmul(med_w, baseline_smoothing_coeff_ff);
            level_ff <= level_ff + fmul(med_w - level_ff, output_smoothing_coeff_ff);
            if (nxt_isr[`CTS_ISR_TOUCH_ENTER_FLAG] && !isr_ff[`CTS_ISR_TOUCH_ENTER_FLAG])
              touch_ff <= 1'b1;
            if (nxt_isr[`CTS_ISR_TOUCH_EXIT_FLAG] && !isr_ff[`CTS_ISR_TOUCH_EXIT_FLAG])
              touch_ff <= 1'b0;
            rpt_ff <= 4'h0;
            acc_ff <= 20'h00000;
            if (transfer_mode_bit_w)
            begin
              st_ff <= ST_DMA;
              dma_dir_ff <= 1'b1;
            end
            else
              st_ff <= ST_CHARGE;
          end
          ST_DMA: ;
          default: st_ff <= ST_IDLE;
        endcase
      end
    end
  end
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_rdata <= 32'h00000000;
    else if (i_rd)
    begin
      case (i_addr)
        `CTS_OFF_CTRL: o_rdata <= {24'h000000, ctrl_ff};
        `CTS_OFF_CNT: o_rdata <= {12'h000, rep_ff, top_ff};
        `CTS_OFF_TIMING: o_rdata <= {4'h0, output_smoothing_coeff_ff, 4'h0, baseline_smoothing_coeff_ff};
        `CTS_OFF_IDLE: o_rdata <= {12'h000, idle_ff};
        `CTS_OFF_LEVEL: o_rdata <= {12'h000, level_ff};
        `CTS_OFF_RAW: o_rdata <= {12'h000, raw0_ff};
        `CTS_OFF_LIMIT: o_rdata <= {12'h000, limit_ff};
        `CTS_OFF_IMR: o_rdata <= {29'h0000000, imr_ff};
        `CTS_OFF_ISR: o_rdata <= {29'h0000000, isr_ff};
        `CTS_OFF_PIN: o_rdata <= {28'h0000000, pin_ff};
        `CTS_OFF_DMA: o_rdata <= dma_acc ? {12'h000, (dma_idx_ff == 3'h0) ? limit_ff :
          (dma_idx_ff == 3'h1) ? idle_ff : level_ff} : 32'h00000000;
        default: o_rdata <= 32'h00000000;
      endcase
    end
    else
      o_rdata <= 32'h00000000;
  end
endmodule

//--- verif/cts_sensor_model.sv
/* Sensor electrodes with their discharge resistor.
   Assumes the sense pins are sampled on i_sys_clk. */
module cts_sensor_model #(
  parameter int DIS_CYC = 6
) (
  input wire logic i_sys_clk,
  input wire logic [15:0] i_sense_out,
  input wire logic [15:0] i_sense_oe_n,
  output logic [15:0] o_sense_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [16];
  // A released pin decays low through the resistor; after being driven high it holds high for DIS_CYC clocks, then reads low
  always @(posedge i_sys_clk)
    for (int k = 0; k < 16; k++)
      if (!i_sense_oe_n[k])
        cnt[k] <= i_sense_out[k] ? DIS_CYC : 0;
      else if (cnt[k] > 0)
        cnt[k] <= cnt[k] - 1;
  always_comb
    for (int k = 0; k < 16; k++)
      o_sense_in[k] = cnt[k] > 0;
endmodule

//--- verif/cts_touch_monitor.sv
/* Port checker for cts_touch_unit.
   Assumes it is bound to every instance of the unit. */
module cts_touch_monitor (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_acq_clk_ok,
  input wire [15:0] o_sense_oe_n,
  input wire o_bleed_pin,
  input wire o_rc_osc_req,
  input wire o_irq,
  input wire o_dma_rx_req,
  input wire o_dma_tx_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  wire ctl_wr = i_wr && i_addr == 8'h00;
  property p_rst_idle;
    $fell(i_rst) |-> o_sense_oe_n == 16'hffff && !o_bleed_pin && !o_rc_osc_req;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("Active after reset");
  property p_rst_quiet;
    $fell(i_rst) |-> !o_irq && !o_dma_rx_req && !o_dma_tx_req;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("Request after reset");
  property p_pins_max2;
    $countones(~o_sense_oe_n) <= 2;
  endproperty
  a_pins_max2: assert property (p_pins_max2) else $error("Too many pins driven");
  property p_clk_abort;
    !i_acq_clk_ok |=> o_sense_oe_n == 16'hffff && !o_rc_osc_req && !o_dma_rx_req;
  endproperty
  a_clk_abort: assert property (p_clk_abort) else $error("No halt on clock loss");
  property p_bleed_nodrive;
    o_bleed_pin |-> o_sense_oe_n == 16'hffff;
  endproperty
  a_bleed_nodrive: assert property (p_bleed_nodrive) else $error("Bleed while charging");
  property p_dma_excl;
    !(o_dma_rx_req && o_dma_tx_req);
  endproperty
  a_dma_excl: assert property (p_dma_excl) else $error("Both transfer requests");
  property p_run_start;
    ctl_wr && i_wdata[1:0] == 2'h3 && !i_wdata[5] && i_acq_clk_ok |-> ##2 o_rc_osc_req;
  endproperty
  a_run_start: assert property (p_run_start) else $error("Run did not start");
  property p_cksel;
    ctl_wr && i_wdata[0] && i_wdata[5] |=> !o_rc_osc_req;
  endproperty
  a_cksel: assert property (p_cksel) else $error("RC request on generic clock");
endmodule
bind cts_touch_unit cts_touch_monitor u_mon (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
  .i_acq_clk_ok, .o_sense_oe_n, .o_bleed_pin, .o_rc_osc_req, .o_irq, .o_dma_rx_req,
  .o_dma_tx_req);

//--- verif/cts_touch_tb_top.sv
/* Bench for cts_touch_unit: register tasks and scenarios.
   Assumes the sensor model and the bound checker. */
module capacitive_touch_acquisition_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TOP = 8;
  logic i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic i_acq_tick = 0, i_acq_clk_ok = 1, i_event_trig = 0;
  logic [7:0] i_addr = 0;
  logic [31:0] i_wdata = 0, rv;
  wire [31:0] o_rdata;
  wire [15:0] i_sense_in, o_sense_out, o_sense_oe_n;
  wire o_bleed_pin, o_rc_osc_req, o_clk_req, o_irq, o_dma_rx_req, o_dma_tx_req;
  int n_fail = 0, compares = 0, cyc = 0, t0, t1;
  always #25 i_sys_clk = ~i_sys_clk;
  // Measurement tick every second cycle, so one tick is 2 clocks
  always @(posedge i_sys_clk)
  begin
    i_acq_tick <= ~i_acq_tick;
    cyc <= cyc + 1;
  end
  cts_touch_unit dut (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_acq_tick, .i_acq_clk_ok, .i_event_trig, .i_sense_in, .o_sense_out, .o_sense_oe_n,
    .o_bleed_pin, .o_rc_osc_req, .o_clk_req, .o_irq, .o_dma_rx_req, .o_dma_tx_req);
  cts_sensor_model u_sen (.i_sys_clk, .i_sense_out(o_sense_out),
    .i_sense_oe_n(o_sense_oe_n), .o_sense_in(i_sense_in));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      n_fail++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1;
    @(posedge i_sys_clk);
    i_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1;
    @(posedge i_sys_clk);
    i_rd <= 0;
    #1 rv = o_rdata;
  endtask
  function logic sel(input int w);
    case (w)
      0: return o_irq;
      1: return o_sense_oe_n != 16'hffff;
      2: return o_bleed_pin;
      3: return o_dma_rx_req;
      default: return o_dma_tx_req;
    endcase
  endfunction
  task wt(input int w);
    int k;
    k = 0;
    // Let the edge that ended the last strobe settle before polling
    #1;
    while (k < 3000 && sel(w) !== 1'b1)
    begin
      @(posedge i_sys_clk);
      #1 k++;
    end
    t1 = cyc;
    if (k == 3000)
      chk("wait", 1, 0);
  endtask
  // Period from one sample flag to the next, with the driven pin mask
  task per(input logic [3:0] pin, input logic [31:0] ctl, cnt, input int e, input logic [15:0] m);
    wr(8'h34, {28'h0, pin});
    wr(8'h04, cnt);
    wr(8'h30, 32'h7);
    wr(8'h00, ctl);
    wt(1);
    chk("pins", m, 16'(~o_sense_oe_n));
    wt(0);
    t0 = t1;
    wr(8'h30, 32'h7);
    wt(0);
    chk("period", e, t1 - t0);
    wr(8'h00, 32'h1);
  endtask
  task end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #1500000;
    n_fail++;
    end_sim;
  end
  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 0;
    rd(8'h00);
    chk("ctrl_rst", 0, rv);
    wr(8'h04, TOP);
    rd(8'h04);
    chk("locked", 0, rv);
    wr(8'h00, 32'h1);
    wr(8'h04, TOP);
    rd(8'h04);
    chk("open", TOP, rv);
    wr(8'h08, 32'h01000001);
    rd(8'h08);
    chk("timing", 32'h01000001, rv);
    wr(8'h18, 32'h7ffff);
    wr(8'h20, 32'h1);
    per(0, 32'h3, TOP, 4 * TOP, 16'h0001);
    per(15, 32'h3, TOP, 4 * TOP, 16'h8000);
    per(4, 32'hb, TOP, 8 * TOP, 16'h0030);
    per(5, 32'h3, 32'h10000 | TOP, 8 * TOP, 16'h0020);
    wr(8'h00, 32'h7);
    wt(2);
    chk("bleed", 1, o_bleed_pin);
    wr(8'h30, 32'h7);
    wt(0);
    rd(8'h00);
    chk("load_clr", 0, rv[2]);
    @(posedge i_sys_clk) i_acq_clk_ok <= 0;
    @(posedge i_sys_clk) i_acq_clk_ok <= 1;
    #1 chk("abort", 16'hffff, o_sense_oe_n);
    chk("abort_req", 0, o_rc_osc_req);
    wr(8'h00, 32'h1);
    rd(8'h2c);
    chk("sample", 1, rv[0]);
    wr(8'h24, 32'h1);
    #1 chk("masked", 0, o_irq);
    @(posedge i_sys_clk) i_event_trig <= 1;
    #1 chk("clk_req", 1, o_clk_req);
    @(posedge i_sys_clk) i_event_trig <= 0;
    wr(8'h00, 32'h43);
    wt(3);
    for (int k = 0; k < 5; k++)
      wr(8'h38, 32'h7ffff);
    wt(4);
    for (int k = 0; k < 5; k++)
    begin
      rd(8'h38);
      if (k == 0)
        chk("dma_limit", 32'h0007ffff, rv);
    end
    #1 chk("tx_done", 0, o_dma_tx_req);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h23);
    @(posedge i_sys_clk);
    #1 chk("generic_clock_rc_req", 0, o_rc_osc_req);
    chk("generic_clock_clk_req", 1, o_clk_req);
    end_sim;
  end
endmodule
